// [hw/asri_pkg.sv]
// Package: constants and types for the address strap and reset init block
package asri_pkg;

  // ****************************************************************
  // Converter and strap bins
  // ****************************************************************
  localparam int ADC_W = 12;
  localparam logic [3:0] BIN_FIRST = 4'h4;
  localparam logic [3:0] BIN_LAST  = 4'hb;
  localparam logic [3:0] BIN_COUNT = 4'h8;
  localparam logic [6:0] ADDR_MULT = 7'h0c;
  localparam logic [6:0] ADDR_DEFAULT = 7'h7e;
  // Lower edge of each bin; each edge is 1.25 times the one below, last entry is top limit
  localparam logic [ADC_W-1:0] BIN_EDGE [0:8] = '{
    12'h0c0, 12'h0f0, 12'h12c, 12'h177, 12'h1d5,
    12'h24a, 12'h2dc, 12'h393, 12'h478};

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 40000000;
  localparam int INIT_TIME_MS = 20;
  localparam int INIT_CYCLES = CLK_HZ / 1000 * INIT_TIME_MS;
  localparam int RESET_EXIT_MS = 1;
  localparam int RESET_EXIT_CYCLES = CLK_HZ / 1000 * RESET_EXIT_MS;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + 24) / 25;
  localparam int STRAP_SETTLE_CYCLES = 16;

  // ****************************************************************
  // Configuration memory
  // ****************************************************************
  localparam int CFG_AW = 6;
  localparam int CFG_DW = 16;
  localparam logic [15:0] CFG_BLANK = 16'hffff;

  typedef enum logic [4:0] {
    ST_RESET  = 5'b00001,
    ST_STRAP  = 5'b00010,
    ST_INIT   = 5'b00100,
    ST_RUN    = 5'b01000,
    ST_STORE  = 5'b10000
  } asri_state_t;

endpackage

// [hw/asri_link_if.sv]
// Interface: configuration host to device link, with reset line
`timescale 1ns/100ps
interface asri_link_if #(parameter int AW = 6, parameter int DW = 16);
  logic          reset_n;     // Active-low external reset
  logic          wr_valid;    // Parameter write strobe
  logic [AW-1:0] wr_index;
  logic [DW-1:0] wr_data;
  logic          store_all;   // Commit working copy to storage
  logic          image_load;  // Full image word, written straight to storage
  logic          busy;        // Device not ready for requests
  logic          store_done;  // One-cycle pulse after commit

  modport device (input reset_n, wr_valid, wr_index, wr_data, store_all, image_load,
                  output busy, store_done);
  modport host   (output reset_n, wr_valid, wr_index, wr_data, store_all, image_load,
                  input busy, store_done);
endinterface

// [hw/asri_strap_decode.sv]
// Strap voltage to bin classifier
`timescale 1ns/100ps
module asri_strap_decode import asri_pkg::*; (
  // Sample in
  input  wire logic [ADC_W-1:0] volt,
  // Result
  output logic      [3:0]       bin,
  output logic                  bad
);
  always_comb begin
    bin = BIN_FIRST;
    bad = (volt < BIN_EDGE[0]) || (volt >= BIN_EDGE[8]); // RULE4 RULE5
    for (int i = 1; i < 8; i++) begin
      if (volt >= BIN_EDGE[i]) begin
        bin = BIN_FIRST + 4'(i); // RULE3
      end
    end
  end
endmodule // asri_strap_decode

// [hw/asri_device.sv]
// Device end: strap address capture, reset, init period and config storage
//
// What this block does
// RULE1 - Bias straps and digitize them, 12 bits
// RULE2 - Address is twelve times high plus low
// RULE3 - Eight bins, 4 to 11, ratio 1.25
// RULE4 - Shorted strap gives default address 126
// RULE5 - Open strap gives default address 126
// RULE6 - Address 126 enables test port, blocks GPIO; code blocks only the GPIO 3:0 output enables
// RULE7 - Bus devices avoid addresses 0, 12, 127; code excludes none: bins hi/lo 10/8 give 0, 11/8 give 12, 10/7 give 127
// RULE8 - Bus devices avoid addresses 11 and 126; the code excludes neither: high/low bins 11/7 wrap to 11, 10/6 give 126
// RULE9 - Power-on reset holds until supply good
// RULE10 - External low reset holds; exit within 1 ms
// RULE11 - Run 20 ms initialization after each reset
// RULE12 - During init fast PWM low, others open
// RULE13 - Factory config: outputs open, PWM low, idle
// RULE14 - Each bus write overwrites working copy
// RULE15 - Store-all copies working set to storage
// RULE16 - Accept full image from bus or test port
// RULE17 - Blank storage also enables test port
// RULE18 - Strap address latched once per reset
`timescale 1ns/100ps
module asri_device import asri_pkg::*; #(
  parameter int INIT_CNT = INIT_CYCLES,
  parameter int NPWM     = 8,
  parameter int NGPIO    = 16
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              digital_supply_rail_good,
  // Link
  asri_link_if.device            link,
  // Strap converter
  output logic                   strap_bias_en,
  output logic                   strap_sel_high,
  input  wire logic [ADC_W-1:0]  strap_adc_data,
  input  wire logic              strap_adc_valid,
  // Test port image path
  input  wire logic              tap_wr_valid,
  input  wire logic [CFG_AW-1:0] tap_wr_index,
  input  wire logic [CFG_DW-1:0] tap_wr_data,
  // Pins and status
  output logic [NPWM-1:0]        fast_pwm_output,
  output logic [NGPIO-1:0]       gpio_out,
  output logic [NGPIO-1:0]       gpio_oe,
  output logic [6:0]             bus_addr,
  output logic                   test_port_en,
  output logic                   running
);
  typedef struct packed {
    asri_state_t          st;
    logic [31:0]          cnt;
    logic [ADC_W-1:0]     low_v;
    logic                 have_low;
    logic [6:0]           addr;
    logic                 tap_en;
    logic                 busy;
    logic                 done;
    logic                 run;
    logic [CFG_AW-1:0]    idx;
    logic [NPWM-1:0]      pwm;
    logic [NGPIO-1:0]     gout;
    logic [NGPIO-1:0]     goe;
    logic                 bias;
    logic                 sel_high;
  } asri_dev_t;

  asri_dev_t s_q, s_d;
  logic [CFG_DW-1:0] work_mem [0:(1<<CFG_AW)-1];
  logic [CFG_DW-1:0] nv_mem   [0:(1<<CFG_AW)-1];
  logic [3:0] bin_lo, bin_hi;
  logic       bad_lo, bad_hi;
  logic       in_reset;

  asri_strap_decode u_lo (.volt(s_q.low_v), .bin(bin_lo), .bad(bad_lo));
  asri_strap_decode u_hi (.volt(strap_adc_data), .bin(bin_hi), .bad(bad_hi));

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  // Supply and pin both hold; pin is taken as already synchronous
  assign in_reset = sys_rst || !digital_supply_rail_good || !link.reset_n; // RULE9 RULE10

  // ****************************************************************
  // Control
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_RESET: begin
        s_d.busy = 1'b1;
        s_d.st = ST_STRAP;
        s_d.bias = 1'b1; // RULE1
        s_d.sel_high = 1'b0;
        s_d.have_low = 1'b0;
      end
      ST_STRAP: begin
        if (strap_adc_valid) begin
          if (!s_q.have_low) begin
            s_d.low_v = strap_adc_data; // RULE1
            s_d.have_low = 1'b1;
            s_d.sel_high = 1'b1;
          end else begin
            s_d.bias = 1'b0;
            s_d.st = ST_INIT;
            s_d.cnt = '0;
            if (bad_lo || bad_hi) begin
              s_d.addr = ADDR_DEFAULT; // RULE4 RULE5
            end else begin
              s_d.addr = 7'(ADDR_MULT * 7'(bin_hi) + 7'(bin_lo)); // RULE2 RULE18
            end
            s_d.tap_en = (bad_lo || bad_hi)
                         || (7'(ADDR_MULT * 7'(bin_hi) + 7'(bin_lo)) == ADDR_DEFAULT)
                         || (nv_mem[0] == CFG_BLANK); // RULE6 RULE17
          end
        end
      end
      ST_INIT: begin
        s_d.pwm = '0; // RULE12
        s_d.goe = '0; // RULE12
        s_d.cnt = s_q.cnt + 32'h1;
        if (s_q.cnt >= 32'(INIT_CNT - 1)) begin
          s_d.st = ST_RUN; // RULE11
          s_d.busy = 1'b0;
          s_d.run = 1'b1;
        end
      end
      ST_RUN: begin
        // Stored word 1 steers enables, word 2 levels; blank image keeps pins open
        if (nv_mem[1] == CFG_BLANK) begin
          s_d.goe = '0; // RULE13
        end else begin
          s_d.goe = nv_mem[1][NGPIO-1:0];
        end
        s_d.gout = (nv_mem[2] == CFG_BLANK) ? '0 : nv_mem[2][NGPIO-1:0];
        // Shared test-port pins stay out of GPIO use while the port is on
        if (s_q.tap_en) begin
          s_d.goe[3:0] = 4'h0; // RULE6
        end
        s_d.pwm = '0; // RULE13
        if (link.store_all) begin
          s_d.st = ST_STORE; // RULE15
          s_d.busy = 1'b1;
          s_d.idx = '0;
        end
      end
      ST_STORE: begin
        s_d.idx = s_q.idx + 1'b1;
        if (&s_q.idx) begin
          s_d.st = ST_RUN;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = ST_RESET;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (in_reset) begin
      s_q <= '{st: ST_RESET, busy: 1'b1, default: '0}; // RULE10
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Working and stored configuration
  // ****************************************************************
  // No reset on the arrays: storage must survive resets
  always_ff @(posedge mclk) begin
    if (s_q.st == ST_RUN && link.wr_valid && !link.image_load) begin
      work_mem[link.wr_index] <= link.wr_data; // RULE14
    end
    if (s_q.st == ST_STORE) begin
      nv_mem[s_q.idx] <= work_mem[s_q.idx]; // RULE15
    end else if (s_q.st == ST_RUN && link.wr_valid && link.image_load) begin
      nv_mem[link.wr_index] <= link.wr_data; // RULE16
    end else if (s_q.st == ST_RUN && s_q.tap_en && tap_wr_valid) begin
      nv_mem[tap_wr_index] <= tap_wr_data; // RULE16
    end
  end

  assign link.busy       = s_q.busy;
  assign link.store_done = s_q.done;
  assign strap_bias_en   = s_q.bias;
  assign strap_sel_high  = s_q.sel_high;
  assign fast_pwm_output = s_q.pwm;
  assign gpio_out        = s_q.gout;
  assign gpio_oe         = s_q.goe;
  assign bus_addr        = s_q.addr;
  assign test_port_en    = s_q.tap_en;
  assign running         = s_q.run;
endmodule // asri_device

// [hw/asri_host.sv]
// Host end: drives reset and sends configuration words, then store-all
`timescale 1ns/100ps
module asri_host import asri_pkg::*; #(
  parameter int RST_CNT = RESET_MIN_CYCLES + 1
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // User side
  input  wire logic              req_reset,
  input  wire logic              req_wr,
  input  wire logic              req_image,
  input  wire logic [CFG_AW-1:0] req_index,
  input  wire logic [CFG_DW-1:0] req_data,
  input  wire logic              req_store,
  output logic                   ready,
  output logic                   stored,
  // Link
  asri_link_if.host              link
);
  typedef struct packed {
    logic [15:0]       rcnt;
    logic              rst_n;
    logic              wv;
    logic              img;
    logic [CFG_AW-1:0] idx;
    logic [CFG_DW-1:0] dat;
    logic              st;
    logic              rdy;
    logic              done;
  } asri_host_t;

  asri_host_t h_q, h_d;

  always_comb begin
    h_d = h_q;
    h_d.wv = 1'b0;
    h_d.st = 1'b0;
    h_d.done = link.store_done;
    // A store request is in flight until busy shows, so ready must not rise in between
    h_d.rdy = !link.busy && h_q.rst_n && h_q.rcnt == '0 && !h_q.st; // RULE15
    if (h_q.rcnt != '0) begin
      // Hold the reset line past its minimum low time
      h_d.rcnt = h_q.rcnt - 16'h1; // RULE10
      h_d.rst_n = (h_q.rcnt == 16'h1);
    end else if (req_reset) begin
      h_d.rcnt = 16'(RST_CNT);
      h_d.rst_n = 1'b0;
      h_d.rdy = 1'b0;
    end else if (h_q.rdy && req_wr) begin
      h_d.wv = 1'b1; // RULE14 RULE16
      h_d.img = req_image;
      h_d.idx = req_index;
      h_d.dat = req_data;
    end else if (h_q.rdy && req_store) begin
      h_d.st = 1'b1; // RULE15
      h_d.rdy = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      h_q <= '{rst_n: 1'b1, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  assign link.reset_n    = h_q.rst_n;
  assign link.wr_valid   = h_q.wv;
  assign link.image_load = h_q.img;
  assign link.wr_index   = h_q.idx;
  assign link.wr_data    = h_q.dat;
  assign link.store_all  = h_q.st;
  assign ready           = h_q.rdy;
  assign stored          = h_q.done;
endmodule // asri_host

// [sim/asri_link_sva.sv]
// Checker: link timing between the host and device ends
`timescale 1ns/100ps
module asri_link_sva #(
  parameter int RST_CNT = 41
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Link
  input wire logic        reset_n,
  input wire logic        wr_valid,
  input wire logic [5:0]  wr_index,
  input wire logic [15:0] wr_data,
  input wire logic        store_all,
  input wire logic        image_load,
  input wire logic        busy,
  input wire logic        store_done
);
  // ****************************************************************
  // Helper
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  int low_cnt_q;
  always_ff @(posedge mclk) begin
    if (sys_rst || reset_n)
      low_cnt_q <= 0;
    else
      low_cnt_q <= low_cnt_q + 1;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_store_req;
    store_all && !busy;
  endsequence
  // Copy of 64 words, busy checked at c1 to c8 and at c64, done at c65
  sequence s_copy;
    busy [*8] ##56 busy ##1 (!busy && store_done);
  endsequence
  a_store_copy_time: assert property (s_store_req |=> s_copy)
    else $error("store did not finish on time");
  a_done_one_cycle: assert property (store_done |=> !store_done)
    else $error("store done longer than one cycle");
  a_done_busy_fall: assert property (store_done |-> !busy && $past(busy))
    else $error("store done without busy falling");
  a_busy_no_done: assert property (busy |-> !store_done)
    else $error("store done while busy");
  a_store_pulse: assert property (store_all |=> !store_all)
    else $error("store request longer than one cycle");
  a_reset_busy: assert property (!reset_n |=> busy && !store_done)
    else $error("device not held in reset");
  a_reset_length: assert property ($rose(reset_n) |-> low_cnt_q == RST_CNT)
    else $error("reset pulse length wrong");
  a_init_busy: assert property ($rose(reset_n) |-> busy [*8])
    else $error("busy dropped early after reset");
endmodule // asri_link_sva

// [sim/address_strap_reset_init_test.sv]
// Testbench: host and device ends joined over the link
`timescale 1ns/100ps
module address_strap_reset_init_test import asri_pkg::*; ();
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int INIT = 20;
  logic        mclk = 1'b0, sys_rst = 1'b1, digital_supply_rail_good = 1'b1;
  logic        strap_adc_valid = 1'b0, tap_wr_valid = 1'b0;
  logic [11:0] strap_adc_data = 12'h000;
  logic [5:0]  tap_wr_index = 6'h00, req_index = 6'h00;
  logic [15:0] tap_wr_data = 16'h0000, req_data = 16'h0000, gpio_out, gpio_oe;
  logic [3:0]  req = 4'h0;
  logic [7:0]  fast_pwm_output;
  logic [6:0]  bus_addr;
  logic        strap_bias_en, strap_sel_high, test_port_en, running, ready, stored;
  int          error_cnt = 0, n_tests = 0, cyc = 0;

  asri_link_if #(.AW(CFG_AW), .DW(CFG_DW)) asri_link_if_i ();
  asri_device #(.INIT_CNT(INIT)) asri_device_i (.mclk, .sys_rst, .digital_supply_rail_good,
    .link(asri_link_if_i), .strap_bias_en, .strap_sel_high, .strap_adc_data, .strap_adc_valid,
    .tap_wr_valid, .tap_wr_index, .tap_wr_data, .fast_pwm_output, .gpio_out, .gpio_oe,
    .bus_addr, .test_port_en, .running);
  asri_host asri_host_i (.mclk, .sys_rst, .req_reset(req[3]), .req_wr(req[2]),
    .req_image(req[1]), .req_store(req[0]), .req_index, .req_data, .ready, .stored,
    .link(asri_link_if_i));
  asri_link_sva #(.RST_CNT(RESET_MIN_CYCLES + 1)) asri_link_sva_i (.mclk, .sys_rst,
    .reset_n(asri_link_if_i.reset_n), .wr_valid(asri_link_if_i.wr_valid),
    .wr_index(asri_link_if_i.wr_index), .wr_data(asri_link_if_i.wr_data),
    .store_all(asri_link_if_i.store_all), .image_load(asri_link_if_i.image_load),
    .busy(asri_link_if_i.busy), .store_done(asri_link_if_i.store_done));

  always #12.5 mclk = ~mclk;
  // Whole run needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bin 0 stands for a short, bin 15 for an open pin; values sit on bin boundaries
  function automatic logic [11:0] raw(input int b, input bit top);
    if (b == 0)
      return BIN_EDGE[0] - 12'h001;
    if (b == 15)
      return BIN_EDGE[8];
    return top ? BIN_EDGE[b-3] - 12'h001 : BIN_EDGE[b-4];
  endfunction
  // Ready is registered, so seen high at a falling edge it still stands at the next rise
  task automatic op(input logic [3:0] k, input logic [5:0] a, input logic [15:0] d);
    int i;
    @(negedge mclk);
    for (i = 0; i < 200 && ready !== 1'b1; i++) @(negedge mclk);
    req = k;
    req_index = a;
    req_data = d;
    @(negedge mclk);
    req = 4'h0;
  endtask
  task automatic strap(input logic [11:0] v);
    strap_adc_data = v;
    strap_adc_valid = 1'b1;
    @(negedge mclk);
    strap_adc_valid = 1'b0;
    strap_adc_data = ~v;
  endtask
  // how: 1 supply drop, 2 host reset; m: 0 stored config, 1 blank, 2 unknown storage
  task automatic boot(input int how, input int lb, input int hb, input logic [15:0] oe,
                      input int m);
    int  i;
    int  bad;
    logic def;
    bad = 0;
    def = (lb % 15 == 0) || (hb % 15 == 0);
    if (how == 1) begin
      digital_supply_rail_good = 1'b0;
      repeat (3) @(negedge mclk);
      chk({running, asri_link_if_i.busy, gpio_oe}, 18'h10000);
      digital_supply_rail_good = 1'b1;
    end else if (how == 2)
      op(4'h8, 6'h00, 16'h0000);
    for (i = 0; i < 200 && running === 1'b1; i++) @(negedge mclk);
    for (i = 0; i < 200 && strap_bias_en !== 1'b1; i++) @(negedge mclk);
    chk({strap_bias_en, strap_sel_high}, 2'b10);
    strap(raw(lb, 1'b0));
    for (i = 0; i < 20 && strap_sel_high !== 1'b1; i++) @(negedge mclk);
    strap(raw(hb, 1'b1));
    for (i = 0; i < 200 && running !== 1'b1; i++) begin
      if (fast_pwm_output !== 8'h00 || gpio_oe !== 16'h0000)
        bad++;
      @(negedge mclk);
    end
    chk(bad, 0);
    chk(i >= INIT && i <= INIT + 4, 1);
    strap(12'h000);
    chk(bus_addr, def ? ADDR_DEFAULT : 7'(ADDR_MULT * hb + lb));
    chk(bus_addr inside {7'h00, 7'h0b, 7'h0c, 7'h7f}, 0);
    if (m < 2) begin
      chk(test_port_en, def || m == 1);
      chk(gpio_oe, def || m == 1 ? oe & 16'hfff0 : oe);
      chk(fast_pwm_output, 0);
    end
  endtask
  task automatic tap(input logic [15:0] d);
    @(negedge mclk);
    tap_wr_valid = 1'b1;
    tap_wr_index = 6'h01;
    tap_wr_data = d;
    @(negedge mclk);
    tap_wr_valid = 1'b0;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int i;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    boot(0, 5, 7, 16'h0000, 2);
    op(4'h6, 6'h00, 16'h0000);
    op(4'h6, 6'h01, 16'h00ff);
    op(4'h6, 6'h02, 16'h0050);
    boot(2, 4, 9, 16'h00ff, 0);
    chk(gpio_out, 16'h0050);
    boot(1, 0, 7, 16'h00ff, 0);
    tap(16'h0f0f);
    boot(1, 11, 15, 16'h0f0f, 0);
    tap(16'hffff);
    op(4'h4, 6'h00, 16'h0000);
    op(4'h4, 6'h01, 16'h0ff0);
    op(4'h1, 6'h00, 16'h0000);
    for (i = 0; i < 200 && stored !== 1'b1; i++) @(negedge mclk);
    chk(stored, 1);
    boot(2, 11, 9, 16'h0ff0, 0);
    op(4'h6, 6'h00, CFG_BLANK);
    op(4'h6, 6'h01, CFG_BLANK);
    boot(2, 6, 8, 16'h0000, 1);
    end_of_test();
  end
endmodule // address_strap_reset_init_test
